// ### inc/wdtc_regs.vh
// Register map, field positions, reset values and codes of the watchdog control block.
`ifndef WDTC_REGS_VH
`define WDTC_REGS_VH

// ============================================================
// Register indices and byte addresses
// ============================================================
// Control register index; its byte address is four times the index.
`define WDTC_CTRL_IDX 8'haa
`define WDTC_CTRL_ADDR 12'h2a8
// Interrupt status, interrupt mask, unlock key and counter view.
`define WDTC_STAT_ADDR 12'h300
`define WDTC_MASK_ADDR 12'h304
`define WDTC_KEY_ADDR 12'h308
`define WDTC_CNT_ADDR 12'h30c
`define WDTC_ADDR_W 12

// ============================================================
// Control register fields
// ============================================================
`define WDTC_RUN_BIT 7
`define WDTC_CLR_BIT 6
`define WDTC_TOF_BIT 5
`define WDTC_LPRUN_BIT 4
`define WDTC_RSTF_BIT 3
`define WDTC_PS_MSB 2
`define WDTC_PS_LSB 0

// Power-on value of the control register.
`define WDTC_CTRL_POR 8'h07
`define WDTC_PS_POR 3'h7
// Configuration field value that selects general-purpose timer use.
`define WDTC_CFG_TIMER 4'hf

// ============================================================
// Interrupt status and mask fields
// ============================================================
`define WDTC_IRQ_TOF_BIT 0
`define WDTC_IRQ_CLR_BIT 1
`define WDTC_IRQ_W 2
`define WDTC_MASK_RST 2'h0

// ============================================================
// Unlock keys
// ============================================================
`define WDTC_KEY_FIRST 8'haa
`define WDTC_KEY_SECOND 8'h55

`endif

// ### logic/wdtc_prescaler.v
// Clock prescaler that turns the watchdog clock into a divided tick.
`timescale 1ns/1ps
`default_nettype none

`include "wdtc_regs.vh"

module wdtc_prescaler #(
   parameter PS_W = 8
) (
   input wire core_clk,
   input wire rst_b,
   input wire restart,
   input wire run,
   input wire [2:0] select,
   output reg tick
);

   // ============================================================
   // Division table
   // ============================================================
   reg [PS_W-1:0] div_last;
   reg [PS_W-1:0] count;

   // Terminal count for each select code: divide by 1, 4, 8 up to 256.
   always @* begin
      case (select)
         3'h0: div_last = 8'h00;
         3'h1: div_last = 8'h03;
         3'h2: div_last = 8'h07;
         3'h3: div_last = 8'h0f;
         3'h4: div_last = 8'h1f;
         3'h5: div_last = 8'h3f;
         3'h6: div_last = 8'h7f;
         default: div_last = 8'hff;
      endcase
   end

   // ============================================================
   // Divider
   // ============================================================
   // Restart wins over counting so a counter clear also drops any partial period.
   always @(posedge core_clk) begin
      if (!rst_b || restart) begin
         count <= {PS_W{1'b0}};
         tick <= 1'b0;
      end else if (run) begin
         if (count >= div_last) begin
            count <= {PS_W{1'b0}};
            tick <= 1'b1;
         end else begin
            count <= count + 8'h01;
            tick <= 1'b0;
         end
      end else begin
         tick <= 1'b0;
      end
   end

endmodule // wdtc_prescaler

`default_nettype wire

// ### logic/wdtc_top.v
// Watchdog timer control block with an AHB-Lite register slave.
//
// Notes on behaviour
// - Run bit acts only in timer configuration.
// - Writing one to clear zeroes the count.
// - Clear bit reads one while clear pending.
// - Overflow sets time-out flag; software clears it.
// - Low-power run bit chooses stop or run; outside timer configuration the count always runs.
// - Watchdog time-out reset sets reset flag.
// - Reset flag: power-on clears, others keep.
// - Three-bit select divides clock 1..256.
// - Select bits all ones at power-on only.
// - Control writes need the unlock sequence.
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

`include "wdtc_regs.vh"

module wdtc_top #(
   parameter CNT_W = 6
) (
   input wire core_clk,
   input wire rst_b,
   input wire por_b,
   input wire [3:0] watchdog_config_enable_field,
   input wire low_power_mode,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   output reg irq,
   output reg watchdog_reset_req
);

   // ============================================================
   // State
   // ============================================================
   reg watchdog_run;
   reg watchdog_counter_clear;
   reg watchdog_timeout_flag;
   reg watchdog_run_in_low_power;
   reg watchdog_reset_flag;
   reg [2:0] watchdog_prescale_select;
   reg reset_pending;
   reg [CNT_W-1:0] count;
   reg [`WDTC_IRQ_W-1:0] irq_status;
   reg [`WDTC_IRQ_W-1:0] irq_mask;
   reg key_half;
   reg key_open;
   reg dp_write;
   reg [`WDTC_ADDR_W-1:0] dp_addr;

   wire addr_phase;
   wire timer_mode;
   wire running;
   wire tick;
   wire overflow;
   wire ctrl_wr;
   wire key_wr;
   wire rd_stat;
   reg [31:0] next_rdata;

   // ============================================================
   // Bus decode
   // ============================================================
   // A transfer is taken when selected, NONSEQ or SEQ, and the bus is ready.
   assign addr_phase = hsel && htrans[1] && hready;
   assign ctrl_wr = dp_write && (dp_addr == `WDTC_CTRL_ADDR) && key_open;
   assign key_wr = dp_write && (dp_addr == `WDTC_KEY_ADDR);
   assign rd_stat = addr_phase && !hwrite
                    && (haddr[`WDTC_ADDR_W-1:0] == `WDTC_STAT_ADDR);

   // Capture the address phase; write data follow in the next cycle.
   always @(posedge core_clk) begin
      if (!rst_b) begin
         dp_write <= 1'b0;
         dp_addr <= {`WDTC_ADDR_W{1'b0}};
      end else begin
         dp_write <= addr_phase && hwrite;
         dp_addr <= haddr[`WDTC_ADDR_W-1:0];
      end
   end

   // The slave never stalls and never reports an error.
   always @(posedge core_clk) begin
      if (!rst_b) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ============================================================
   // Unlock sequence
   // ============================================================
   // Two key writes in a row open one control write; any other write relocks.
   // Only the next bus write can use the opening, so stray code cannot
   // reach the control register much later.
   always @(posedge core_clk) begin
      if (!rst_b) begin
         key_half <= 1'b0;
         key_open <= 1'b0;
      end else if (dp_write) begin
         if (key_wr && hwdata[7:0] == `WDTC_KEY_FIRST) begin
            key_half <= 1'b1;
            key_open <= 1'b0;
         end else if (key_wr && key_half && hwdata[7:0] == `WDTC_KEY_SECOND) begin
            key_half <= 1'b0;
            key_open <= 1'b1;
         end else begin
            key_half <= 1'b0;
            key_open <= 1'b0;
         end
      end
   end

   // ============================================================
   // Run control
   // ============================================================
   // In timer use the run bit and the low-power option gate counting.
   // Outside timer use the watchdog is armed and always counts.
   assign timer_mode = (watchdog_config_enable_field == `WDTC_CFG_TIMER);
   assign running = timer_mode
                    ? (watchdog_run
                       && (!low_power_mode || watchdog_run_in_low_power))
                    : 1'b1;

   wdtc_prescaler #(
      .PS_W(8)
   ) u_prescaler (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .restart(watchdog_counter_clear),
      .run(running),
      .select(watchdog_prescale_select),
      .tick(tick)
   );

   // A tick with the counter at its top value is the overflow event.
   assign overflow = tick && running && (&count);

   // ============================================================
   // Watchdog counter
   // ============================================================
   // A pending clear zeroes the count one cycle after it is written.
   always @(posedge core_clk) begin
      if (!rst_b) begin
         count <= {CNT_W{1'b0}};
      end else if (watchdog_counter_clear) begin
         count <= {CNT_W{1'b0}};
      end else if (tick && running) begin
         count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // ============================================================
   // Control register
   // ============================================================
   // Ordinary control bits are cleared by every reset; the select field and
   // the reset flag follow only power-on.
   always @(posedge core_clk) begin
      if (!rst_b) begin
         watchdog_run <= 1'b0;
         watchdog_counter_clear <= 1'b0;
         watchdog_timeout_flag <= 1'b0;
         watchdog_run_in_low_power <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            watchdog_run <= hwdata[`WDTC_RUN_BIT];
            watchdog_run_in_low_power <= hwdata[`WDTC_LPRUN_BIT];
         end
         // Writing zero leaves a pending clear alone; it drops once done.
         if (ctrl_wr && hwdata[`WDTC_CLR_BIT]) begin
            watchdog_counter_clear <= 1'b1;
         end else begin
            watchdog_counter_clear <= 1'b0;
         end
         // Hardware set wins over a software clear in the same cycle.
         if (overflow) begin
            watchdog_timeout_flag <= 1'b1;
         end else if (ctrl_wr) begin
            watchdog_timeout_flag <= hwdata[`WDTC_TOF_BIT];
         end
      end
   end

   // Power-on-only fields: prescale select and the watchdog reset flag.
   always @(posedge core_clk) begin
      if (!por_b) begin
         watchdog_prescale_select <= `WDTC_PS_POR;
         watchdog_reset_flag <= 1'b0;
         reset_pending <= 1'b0;
      end else if (!rst_b) begin
         // A reset that the watchdog caused marks the flag; others keep it.
         watchdog_reset_flag <= watchdog_reset_flag | reset_pending;
         reset_pending <= 1'b0;
      end else begin
         if (!timer_mode && overflow) begin
            reset_pending <= 1'b1;
         end
         if (ctrl_wr) begin
            watchdog_prescale_select <= hwdata[`WDTC_PS_MSB:`WDTC_PS_LSB];
            watchdog_reset_flag <= hwdata[`WDTC_RSTF_BIT];
         end
      end
   end

   // Reset request stays high until the system reset arrives.
   always @(posedge core_clk) begin
      if (!por_b || !rst_b) begin
         watchdog_reset_req <= 1'b0;
      end else begin
         watchdog_reset_req <= reset_pending || (!timer_mode && overflow);
      end
   end

   // ============================================================
   // Interrupt status and mask
   // ============================================================
   // Sticky events: the time-out and the end of a counter clear.
   // A read of the status clears it, but an event in that cycle survives.
   always @(posedge core_clk) begin
      if (!rst_b) begin
         irq_status <= {`WDTC_IRQ_W{1'b0}};
      end else begin
         irq_status[`WDTC_IRQ_TOF_BIT] <= overflow
            || (irq_status[`WDTC_IRQ_TOF_BIT] && !rd_stat);
         irq_status[`WDTC_IRQ_CLR_BIT] <= watchdog_counter_clear
            || (irq_status[`WDTC_IRQ_CLR_BIT] && !rd_stat);
      end
   end

   // Mask register, written directly without the unlock sequence.
   always @(posedge core_clk) begin
      if (!rst_b) begin
         irq_mask <= `WDTC_MASK_RST;
      end else if (dp_write && dp_addr == `WDTC_MASK_ADDR) begin
         irq_mask <= hwdata[`WDTC_IRQ_W-1:0];
      end
   end

   // Level interrupt, registered so the output comes from a flip-flop.
   always @(posedge core_clk) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end

   // ============================================================
   // Read data
   // ============================================================
   // Read data are prepared from the address phase so the data phase
   // needs no wait state.
   always @* begin
      next_rdata = 32'h0000_0000;
      case (haddr[`WDTC_ADDR_W-1:0])
         `WDTC_CTRL_ADDR: begin
            next_rdata[`WDTC_RUN_BIT] = watchdog_run;
            next_rdata[`WDTC_CLR_BIT] = watchdog_counter_clear;
            next_rdata[`WDTC_TOF_BIT] = watchdog_timeout_flag;
            next_rdata[`WDTC_LPRUN_BIT] = watchdog_run_in_low_power;
            next_rdata[`WDTC_RSTF_BIT] = watchdog_reset_flag;
            next_rdata[`WDTC_PS_MSB:`WDTC_PS_LSB] = watchdog_prescale_select;
         end
         `WDTC_STAT_ADDR: next_rdata[`WDTC_IRQ_W-1:0] = irq_status;
         `WDTC_MASK_ADDR: next_rdata[`WDTC_IRQ_W-1:0] = irq_mask;
         `WDTC_KEY_ADDR: next_rdata[0] = key_open;
         `WDTC_CNT_ADDR: next_rdata[CNT_W-1:0] = count;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Unmapped addresses read as zero with an OKAY response.
   always @(posedge core_clk) begin
      if (!rst_b) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         hrdata <= next_rdata;
      end
   end

endmodule // wdtc_top

`default_nettype wire

// ### sim/wdtc_checker.sv
// Port-level assertions for the watchdog control block.
`timescale 1ns/1ps
`default_nettype none
`include "wdtc_regs.vh"
// ============================================================
// Checker
// ============================================================
module wdtc_checker #(
   parameter int CNT_W = 6
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic por_b,
   input wire logic [3:0] watchdog_config_enable_field,
   input wire logic low_power_mode,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic irq,
   input wire logic watchdog_reset_req
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // An accepted read address phase; the data follows one edge later.
   sequence s_rd(logic [11:0] a);
      hsel && htrans[1] && hready && !hwrite && haddr == {20'h0, a};
   endsequence
   sequence s_rd_unmapped;
      hsel && htrans[1] && hready && !hwrite && haddr[31:12] == 20'h0
         && haddr[11:0] > `WDTC_CNT_ADDR;
   endsequence
   a_ready_high: assert property (hreadyout) else $error("wait state seen");
   a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> !irq && hrdata == 32'h0
      && !watchdog_reset_req) else $error("outputs not quiet after reset");
   a_req_cause: assert property ($rose(watchdog_reset_req) |->
      $past(watchdog_config_enable_field) != `WDTC_CFG_TIMER) else $error("request in timer use");
   // The request may only fall at the edge that samples the system reset low.
   a_req_holds: assert property (watchdog_reset_req && rst_b |=> watchdog_reset_req)
      else $error("reset request dropped");
   a_ctrl_byte: assert property (s_rd(`WDTC_CTRL_ADDR) |=> hrdata[31:8] == 24'h0)
      else $error("control upper bits set");
   a_key_bit: assert property (s_rd(`WDTC_KEY_ADDR) |=> hrdata[31:1] == 31'h0)
      else $error("key read upper bits set");
   a_cnt_width: assert property (s_rd(`WDTC_CNT_ADDR) |=> (hrdata >> CNT_W) == 32'h0)
      else $error("counter wider than set");
   a_unmapped_zero: assert property (s_rd_unmapped |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
endmodule // wdtc_checker
bind wdtc_top wdtc_checker #(.CNT_W(CNT_W)) u_chk (.core_clk(core_clk), .rst_b(rst_b),
   .por_b(por_b), .watchdog_config_enable_field(watchdog_config_enable_field),
   .low_power_mode(low_power_mode), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .watchdog_reset_req(watchdog_reset_req));
`default_nettype wire

// ### sim/wdtc_tb_top.sv
// Self-checking bench for the watchdog control block.
`timescale 1ns/1ps
`default_nettype none
`include "wdtc_regs.vh"
module wdtc_tb_top;
   // A short counter keeps overflows close together.
   localparam int CNT_W = 4;
   logic core_clk, rst_b, por_b, low_power_mode, hsel, hwrite;
   logic [3:0] cfg;
   logic [31:0] haddr, hwdata, r, a, m;
   logic [1:0] htrans;
   logic [2:0] hsize, sel, rnd;
   wire [31:0] hrdata;
   wire hready, hreadyout, hresp, irq, watchdog_reset_req;
   int fail_count = 0;
   int check_count = 0;
   int cycles = 0;
   int div;
   // The single slave drives the bus ready.
   assign hready = hreadyout;
   wdtc_top #(.CNT_W(CNT_W)) dut (.core_clk(core_clk), .rst_b(rst_b), .por_b(por_b),
      .watchdog_config_enable_field(cfg), .low_power_mode(low_power_mode), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
      .watchdog_reset_req(watchdog_reset_req));
   // ============================================================
   // Clock, timeout and tasks
   // ============================================================
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // The plan needs about 4400 cycles, so a hang is cut well after that.
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 12000) begin
         fail_count++;
         final_report();
      end
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Tick phase after a restart is not pinned, so a count may be two off.
   task automatic check_near(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if ($isunknown(got) || got + 2 < exp || got > exp + 2) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One single transfer; each phase is held until ready is seen.
   task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= ad;
      hwrite <= w;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic unlock_wr(input logic [31:0] d);
      bus(1'b1, `WDTC_KEY_ADDR, `WDTC_KEY_FIRST);
      bus(1'b1, `WDTC_KEY_ADDR, `WDTC_KEY_SECOND);
      bus(1'b1, `WDTC_CTRL_ADDR, d);
   endtask
   task automatic do_reset(input logic por);
      @(posedge core_clk);
      rst_b <= 1'b0;
      por_b <= ~por;
      @(posedge core_clk);
      rst_b <= 1'b1;
      por_b <= 1'b1;
   endtask
   // Two counter reads spaced eight edges apart at their address phases.
   task automatic cnt_pair();
      bus(1'b0, `WDTC_CNT_ADDR, 0);
      a = r;
      repeat (5) @(posedge core_clk);
      bus(1'b0, `WDTC_CNT_ADDR, 0);
   endtask
   // ============================================================
   // Main sequence
   // ============================================================
   initial begin
      rst_b = 1'b0;
      por_b = 1'b0;
      cfg = `WDTC_CFG_TIMER;
      {low_power_mode, hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      void'($urandom(50054));
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      por_b <= 1'b1;
      bus(1'b0, `WDTC_CTRL_ADDR, 0);
      check_val(r, 32'h07);
      bus(1'b1, `WDTC_CTRL_ADDR, 32'h80);
      bus(1'b0, `WDTC_CTRL_ADDR, 0);
      check_val(r, 32'h07);
      bus(1'b0, `WDTC_CNT_ADDR, 0);
      check_val(r, 32'h0);
      a = 32'h310 + (($urandom % 16) << 2);
      bus(1'b1, a, $urandom);
      bus(1'b0, a, 0);
      check_val(r, 32'h0);
      // Every select, in a shuffled order, with a clear to restart the count.
      rnd = 3'($urandom % 8);
      for (int s = 0; s < 8; s++) begin
         sel = 3'(s) ^ rnd;
         div = (sel == 0) ? 1 : (2 << sel);
         unlock_wr({24'h0, 8'hc0 | {5'h0, sel}});
         repeat (8 * div) @(posedge core_clk);
         bus(1'b0, `WDTC_CNT_ADDR, 0);
         check_near(r, 32'h8);
      end
      bus(1'b0, `WDTC_CTRL_ADDR, 0);
      check_val(r, {24'h0, 5'h10, sel});
      unlock_wr(32'hc0);
      low_power_mode <= 1'b1;
      cnt_pair();
      check_val(r, a);
      unlock_wr(32'h90);
      cnt_pair();
      check_val(r, (a + 8) & ((32'h1 << CNT_W) - 1));
      repeat (16) @(posedge core_clk);
      low_power_mode <= 1'b0;
      unlock_wr(32'h20);
      bus(1'b0, `WDTC_CTRL_ADDR, 0);
      check_val(r, 32'h20);
      cnt_pair();
      check_val(r, a);
      m = 32'h1 | ($urandom & 32'h2);
      bus(1'b1, `WDTC_MASK_ADDR, m);
      repeat (2) @(posedge core_clk);
      check_val({31'h0, irq}, 32'h1);
      bus(1'b0, `WDTC_STAT_ADDR, 0);
      check_val(r, 32'h3);
      repeat (2) @(posedge core_clk);
      check_val({31'h0, irq}, 32'h0);
      bus(1'b0, `WDTC_STAT_ADDR, 0);
      check_val(r, 32'h0);
      unlock_wr(32'h00);
      bus(1'b0, `WDTC_CNT_ADDR, 0);
      check_val(r, a);
      bus(1'b0, `WDTC_CTRL_ADDR, 0);
      check_val(r, 32'h0);
      unlock_wr(32'h40);
      bus(1'b0, `WDTC_CNT_ADDR, 0);
      check_val(r, 32'h0);
      bus(1'b0, `WDTC_CTRL_ADDR, 0);
      check_val(r, 32'h0);
      bus(1'b0, `WDTC_STAT_ADDR, 0);
      check_val(r, 32'h2);
      // Reset mode: the counter runs free and must ask for a reset.
      cfg <= 4'($urandom % 15);
      for (int i = 0; i < 200 && watchdog_reset_req !== 1'b1; i++) @(posedge core_clk);
      check_val({31'h0, watchdog_reset_req}, 32'h1);
      cfg <= `WDTC_CFG_TIMER;
      do_reset(1'b0);
      bus(1'b0, `WDTC_CTRL_ADDR, 0);
      check_val(r, 32'h08);
      do_reset(1'b0);
      bus(1'b0, `WDTC_CTRL_ADDR, 0);
      check_val(r, 32'h08);
      unlock_wr(32'h0d);
      do_reset(1'b0);
      bus(1'b0, `WDTC_CTRL_ADDR, 0);
      check_val(r, 32'h0d);
      do_reset(1'b1);
      bus(1'b0, `WDTC_CTRL_ADDR, 0);
      check_val(r, 32'h07);
      final_report();
   end
endmodule // wdtc_tb_top
`default_nettype wire
